// ===== hw/ddrcb_pkg.sv
package ddrcb_pkg;

   localparam int NUM_BANKS  = 8;
   localparam int BANK_W     = 3;
   localparam int ROW_W      = 13;
   localparam int COL_W      = 10;
   localparam int AP_BIT     = 10;
   localparam int AL_MAX     = 6;
   localparam int AL_W       = 3;
   localparam int CNT_W      = 5;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_RFC_NS      = 128;
   localparam int T_RFC_CYC     = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_WR_NS       = 15;
   localparam int T_WR_CYC      = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Reset values
   localparam logic [NUM_BANKS-1:0] BANKS_RST = 8'h00;
   localparam logic [ROW_W-1:0]     ROW_RST   = 13'h0000;

   typedef enum logic [2:0] {
      DDRCB_CMD_NOP,
      DDRCB_CMD_ACT,
      DDRCB_CMD_RD,
      DDRCB_CMD_WR,
      DDRCB_CMD_PRE,
      DDRCB_CMD_REF,
      DDRCB_CMD_SRE,
      DDRCB_CMD_OTHER
   } ddrcb_cmd_t;

   typedef enum logic [1:0] {
      DDRCB_ST_NORMAL,
      DDRCB_ST_SELF_REF,
      DDRCB_ST_REF_BUSY
   } ddrcb_state_t;

   // Command pins as sampled, active-low strobes
   typedef struct packed {
      logic              cke;
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BANK_W-1:0] ba;
      logic [ROW_W-1:0]  addr;
   } ddrcb_pins_t;

   // Internally issued column access
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              auto_pre;
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0]  col;
   } ddrcb_col_t;

endpackage

// ===== hw/ddrcb_core.sv
// Function
// - Activate decodes CS,RAS low, CAS,WE high; bank and row captured.
// - Read or write accepted the cycle right after its bank's activate.
// - Additive latency 0 to 6 delays column commands to meet tRCD.
// - Read decodes CS,CAS low, RAS,WE high; burst read at column A0-A9.
// - Write decodes CS,CAS,WE low, RAS high; burst write at column A0-A9.
// - A10 high on read or write selects auto-precharge after burst.
// - Read auto-precharge starts AL plus BL/2 cycles after command.
// - Write auto-precharge starts after burst end plus write recovery.
// - Precharge all decodes CS,RAS,WE low, CAS high, A10 high; closes all.
// - Self-refresh entry on refresh code with CKE low; DLL off, inputs ignored.
// - Refresh decodes CS,RAS,CAS low, WE,CKE high; banks left idle.
// - CS low with RAS, CAS, WE high does nothing, like deselect.
// - CS high ignores RAS, CAS, WE and address inputs.
module ddrcb_core
   import ddrcb_pkg::*;
(
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          reset,
   // Command pins from the controller
   input  wire ddrcb_pkg::ddrcb_pins_t        pins_in,
   // Mode settings
   input  wire logic [ddrcb_pkg::AL_W-1:0]    add_lat,
   input  wire logic                          burst_len8,
   // Internal column access and bank state
   output ddrcb_pkg::ddrcb_col_t              col_issue,
   output logic [ddrcb_pkg::NUM_BANKS-1:0]    bank_active,
   output logic [ddrcb_pkg::ROW_W-1:0]        open_row [ddrcb_pkg::NUM_BANKS],
   // Power state, refresh status and command error
   output logic                               self_refresh,
   output logic                               dll_on,
   output logic                               refresh_busy,
   output logic [ddrcb_pkg::ROW_W-1:0]        refresh_row,
   output logic                               cmd_error
);
   import ddrcb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchroniser
   ddrcb_pins_t pins_s1_reg;
   ddrcb_pins_t pins_reg;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         pins_s1_reg <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                          ba: '0, addr: '0};
         pins_reg    <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                          ba: '0, addr: '0};
      end
      else
      begin
         pins_s1_reg <= pins_in;
         pins_reg    <= pins_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   ddrcb_cmd_t cmd;
   logic       cke_prev_reg;

   always_comb
   begin
      cmd = DDRCB_CMD_NOP;
      if (!pins_reg.cs_n)
      begin
         unique case ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n})
            3'b011:  cmd = DDRCB_CMD_ACT;
            3'b101:  cmd = DDRCB_CMD_RD;
            3'b100:  cmd = DDRCB_CMD_WR;
            3'b010:  cmd = pins_reg.addr[AP_BIT] ? DDRCB_CMD_PRE
                                                 : DDRCB_CMD_OTHER;
            3'b001:  cmd = pins_reg.cke ? DDRCB_CMD_REF
                         : (cke_prev_reg ? DDRCB_CMD_SRE : DDRCB_CMD_NOP);
            3'b111:  cmd = DDRCB_CMD_NOP;
            default: cmd = DDRCB_CMD_OTHER;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state machine
   ddrcb_state_t          state_reg, state_next;
   logic [CNT_W-1:0]      rfc_cnt_reg, rfc_cnt_next;
   logic [ROW_W-1:0]      ref_row_reg, ref_row_next;
   logic                  accept;

   assign accept = (state_reg != DDRCB_ST_SELF_REF);

   always_comb
   begin
      state_next   = state_reg;
      rfc_cnt_next = rfc_cnt_reg;
      ref_row_next = ref_row_reg;
      unique case (state_reg)
         DDRCB_ST_NORMAL:
         begin
            if (cmd == DDRCB_CMD_REF)
            begin
               state_next   = DDRCB_ST_REF_BUSY;
               rfc_cnt_next = CNT_W'(T_RFC_CYC - 1);
               ref_row_next = ref_row_reg + 13'h0001;
            end
            else if (cmd == DDRCB_CMD_SRE)
               state_next = DDRCB_ST_SELF_REF;
         end
         DDRCB_ST_REF_BUSY:
         begin
            if (rfc_cnt_reg != '0)
               rfc_cnt_next = rfc_cnt_reg - 5'h01;
            else if (cmd == DDRCB_CMD_REF)
            begin
               // Refresh exactly one tRFC after the last one restarts the timer
               rfc_cnt_next = CNT_W'(T_RFC_CYC - 1);
               ref_row_next = ref_row_reg + 13'h0001;
            end
            else
               state_next = DDRCB_ST_NORMAL;
         end
         DDRCB_ST_SELF_REF:
         begin
            if (pins_reg.cke)
               state_next = DDRCB_ST_NORMAL;
         end
         default: state_next = DDRCB_ST_NORMAL;
      endcase
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_reg    <= DDRCB_ST_NORMAL;
         rfc_cnt_reg  <= '0;
         ref_row_reg  <= ROW_RST;
         cke_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         rfc_cnt_reg  <= rfc_cnt_next;
         ref_row_reg  <= ref_row_next;
         cke_prev_reg <= pins_reg.cke;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Additive latency delay line
   ddrcb_col_t al_pipe_reg [AL_MAX+1];
   ddrcb_col_t al_pipe_next [AL_MAX+1];
   ddrcb_col_t col_new;

   always_comb
   begin
      col_new          = '0;
      col_new.valid    = accept && (cmd == DDRCB_CMD_RD || cmd == DDRCB_CMD_WR);
      col_new.write    = (cmd == DDRCB_CMD_WR);
      col_new.auto_pre = pins_reg.addr[AP_BIT];
      col_new.bank     = pins_reg.ba;
      col_new.col      = pins_reg.addr[COL_W-1:0];
   end

   // Stage k holds a command that issues after k more cycles
   generate
      for (genvar k = 0; k <= AL_MAX; k++)
      begin : g_al
         always_comb
         begin
            al_pipe_next[k] = (k < AL_MAX) ? al_pipe_reg[(k < AL_MAX) ? k + 1 : k]
                                           : ddrcb_col_t'('0);
            if (col_new.valid && add_lat == AL_W'(k))
               al_pipe_next[k] = col_new;
         end
         always_ff @(posedge mclk or posedge reset)
         begin
            if (reset)
               al_pipe_reg[k] <= '0;
            else
               al_pipe_reg[k] <= al_pipe_next[k];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Per-bank state and auto-precharge timers
   logic [NUM_BANKS-1:0] act_reg, act_next;
   logic [ROW_W-1:0]     row_reg [NUM_BANKS];
   logic [ROW_W-1:0]     row_next [NUM_BANKS];
   logic [CNT_W-1:0]     ap_cnt_reg [NUM_BANKS];
   logic [CNT_W-1:0]     ap_cnt_next [NUM_BANKS];
   logic [NUM_BANKS-1:0] ap_pend_reg, ap_pend_next;
   logic [CNT_W-1:0]     ap_delay;

   // Read: AL + BL/2 counted from command; here counted from internal issue
   always_comb
   begin
      if (al_pipe_next[0].write)
         ap_delay = CNT_W'(int'(add_lat) + (burst_len8 ? 4 : 2) - 1 + T_WR_CYC);
      else
         ap_delay = CNT_W'(burst_len8 ? 4 : 2);
   end

   generate
      for (genvar b = 0; b < NUM_BANKS; b++)
      begin : g_bank
         always_comb
         begin
            act_next[b]     = act_reg[b];
            row_next[b]     = row_reg[b];
            ap_cnt_next[b]  = ap_cnt_reg[b];
            ap_pend_next[b] = ap_pend_reg[b];
            if (ap_pend_reg[b])
            begin
               if (ap_cnt_reg[b] <= 5'h01)
               begin
                  ap_pend_next[b] = 1'b0;
                  act_next[b]     = 1'b0;
               end
               else
                  ap_cnt_next[b] = ap_cnt_reg[b] - 5'h01;
            end
            if (al_pipe_next[0].valid && al_pipe_next[0].auto_pre
                && al_pipe_next[0].bank == BANK_W'(b))
            begin
               ap_pend_next[b] = 1'b1;
               ap_cnt_next[b]  = ap_delay;
            end
            if (accept && cmd == DDRCB_CMD_ACT && pins_reg.ba == BANK_W'(b))
            begin
               act_next[b] = 1'b1;
               row_next[b] = pins_reg.addr;
            end
            if (accept && (cmd == DDRCB_CMD_PRE || cmd == DDRCB_CMD_REF))
            begin
               act_next[b]     = 1'b0;
               ap_pend_next[b] = 1'b0;
            end
         end
         always_ff @(posedge mclk or posedge reset)
         begin
            if (reset)
            begin
               act_reg[b]     <= BANKS_RST[b];
               row_reg[b]     <= ROW_RST;
               ap_cnt_reg[b]  <= '0;
               ap_pend_reg[b] <= 1'b0;
            end
            else
            begin
               act_reg[b]     <= act_next[b];
               row_reg[b]     <= row_next[b];
               ap_cnt_reg[b]  <= ap_cnt_next[b];
               ap_pend_reg[b] <= ap_pend_next[b];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   logic err_next;

   // Column access to an idle bank, activate to an open bank, or activate or refresh inside tRFC flags an error
   always_comb
   begin
      err_next = 1'b0;
      if (accept && (cmd == DDRCB_CMD_RD || cmd == DDRCB_CMD_WR) && !act_reg[pins_reg.ba])
         err_next = 1'b1;
      if (accept && cmd == DDRCB_CMD_ACT && act_reg[pins_reg.ba])
         err_next = 1'b1;
      if (state_reg == DDRCB_ST_REF_BUSY && rfc_cnt_reg != '0
          && (cmd == DDRCB_CMD_ACT || cmd == DDRCB_CMD_REF))
         err_next = 1'b1;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         col_issue    <= '0;
         self_refresh <= 1'b0;
         dll_on       <= 1'b1;
         refresh_busy <= 1'b0;
         refresh_row  <= ROW_RST;
         cmd_error    <= 1'b0;
      end
      else
      begin
         col_issue    <= al_pipe_reg[0];
         self_refresh <= (state_reg == DDRCB_ST_SELF_REF);
         dll_on       <= (state_reg != DDRCB_ST_SELF_REF);
         refresh_busy <= (state_reg == DDRCB_ST_REF_BUSY);
         refresh_row  <= ref_row_reg;
         cmd_error    <= err_next;
      end
   end

   assign bank_active = act_reg;
   assign open_row    = row_reg;

endmodule // ddrcb_core

// ===== tb/ddrcb_ctrl_model.sv
module ddrcb_ctrl_model
   import ddrcb_pkg::*;
#(
   parameter int T_RP_CYC   = 3,
   parameter int T_XSNR_CYC = 10,
   parameter int T_AOFD_CYC = 3,
   parameter int T_MOD_CYC  = 12
)
(
   // Clock
   input  wire logic              mclk,
   // Command pins toward the device
   output ddrcb_pkg::ddrcb_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ns;
   import ddrcb_pkg::*;
   logic ck = 1'b1;
   // Termination line toward the pad; the block has no pin for it
   logic odt = 1'b0;

   initial pins = {1'b1, 1'b1, 19'h0};

   task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
                       input logic k);
      @(negedge mclk);
      ck = k;
      pins <= {k, c, b, a};
   endtask

   // Deselect; released lines toggle so a stale value never looks valid
   task automatic idle(input int n);
      repeat (n)
      begin
         @(negedge mclk);
         pins <= {ck, 1'b1, ~pins[18:0]};
      end
   endtask

   task automatic prea();
      send(4'h2, 3'h7, 13'h0400, 1'b1);
      idle(T_RP_CYC + 1);
   endtask

   task automatic sr_exit();
      send(4'h7, 3'h0, 13'h0000, 1'b1);
      idle(T_XSNR_CYC);
      send(4'h1, 3'h0, 13'h0000, 1'b1);
      idle(T_RFC_CYC + 2);
   endtask

   task automatic sr_entry();
      odt = 1'b0;
      send(4'h1, 3'h0, 13'h0000, 1'b0);
   endtask

   // Termination update: ODT low first, then turn-off delay, CKE high through tMOD
   task automatic term_update(input logic [12:0] a);
      odt = 1'b0;
      idle(T_AOFD_CYC);
      send(4'h0, 3'h1, a, 1'b1);
      idle(T_MOD_CYC);
      odt = 1'b1;
   endtask
endmodule // ddrcb_ctrl_model

// ===== tb/ddrcb_core_monitor.sv
module ddrcb_core_monitor
   import ddrcb_pkg::*;
(
   // Clock and reset
   input wire logic                   mclk,
   input wire logic                   reset,
   // Inputs
   input wire ddrcb_pkg::ddrcb_pins_t pins_in,
   input wire logic [2:0]             add_lat,
   input wire logic                   burst_len8,
   // Outputs
   input wire ddrcb_pkg::ddrcb_col_t  col_issue,
   input wire logic [7:0]             bank_active,
   input wire logic [12:0]            open_row [8],
   input wire logic                   self_refresh,
   input wire logic                   dll_on,
   input wire logic                   refresh_busy,
   input wire logic [12:0]            refresh_row,
   input wire logic                   cmd_error
);
   timeunit 1ns;
   timeprecision 1ns;
   import ddrcb_pkg::*;
   logic [3:0] c;
   logic       go;
   assign c  = {pins_in.cs_n, pins_in.ras_n, pins_in.cas_n, pins_in.we_n};
   assign go = pins_in.cke && !self_refresh && !refresh_busy;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   chk_act_opens_bank: assert property (go && c == 4'h3 && !bank_active[pins_in.ba] |->
      ##3 bank_active[$past(pins_in.ba, 3)] && open_row[$past(pins_in.ba, 3)] ==
      $past(pins_in.addr, 3)) else $error("activate did not open the row");
   chk_rd_issue: assert property (go && c == 4'h5 && add_lat == 3'h0 |-> ##4
      col_issue.valid && !col_issue.write && col_issue.bank == $past(pins_in.ba, 4)
      && col_issue.col == $past(pins_in.addr[9:0], 4)) else $error("read not issued");
   chk_wr_issue: assert property (go && c == 4'h4 && add_lat == 3'h0 |-> ##4
      col_issue.valid && col_issue.write && col_issue.auto_pre == $past(pins_in.addr[10], 4)
      && col_issue.col == $past(pins_in.addr[9:0], 4)) else $error("write not issued");
   chk_prea_closes: assert property (go && c == 4'h2 && pins_in.addr[10] |->
      ##3 bank_active == 8'h00) else $error("precharge all left a bank open");
   chk_ref_idles: assert property (go && c == 4'h1 && $past(pins_in.cke) |-> ##4
      bank_active == 8'h00 && refresh_busy && refresh_row == $past(refresh_row, 4) + 13'h1)
      else $error("refresh did not run");
   chk_only_act_opens: assert property (|(bank_active & ~$past(bank_active)) |->
      $past(c, 3) == 4'h3) else $error("bank opened without activate");
   chk_sr_entry: assert property (c == 4'h1 && !pins_in.cke && $past(pins_in.cke)
      && !self_refresh |-> ##4 self_refresh && !dll_on) else $error("no self refresh");
   chk_sr_hold: assert property (self_refresh && !pins_in.cke && !$past(pins_in.cke) &&
      !$past(pins_in.cke, 2) |=> self_refresh && !col_issue.valid) else $error("left early");
   chk_dll_off: assert property (self_refresh |-> !dll_on)
      else $error("dll on in self refresh");
   cover property (col_issue.valid && col_issue.auto_pre);
   cover property ($rose(self_refresh));
   cover property (refresh_busy && bank_active == 8'h00);
endmodule // ddrcb_core_monitor

bind ddrcb_core ddrcb_core_monitor i_ddrcb_core_monitor (
   .mclk(mclk), .reset(reset), .pins_in(pins_in), .add_lat(add_lat),
   .burst_len8(burst_len8), .col_issue(col_issue), .bank_active(bank_active),
   .open_row(open_row), .self_refresh(self_refresh), .dll_on(dll_on),
   .refresh_busy(refresh_busy), .refresh_row(refresh_row), .cmd_error(cmd_error)
);

// ===== tb/ddrcb_core_tb.sv
module ddrcb_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ddrcb_pkg::*;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  add_lat = 3'h0;
   logic        burst_len8 = 1'b0;
   ddrcb_pins_t pins_in;
   ddrcb_col_t  col_issue;
   logic [7:0]  bank_active;
   logic [12:0] open_row [8];
   logic [12:0] refresh_row;
   logic        self_refresh, dll_on, refresh_busy, cmd_error, seen;
   int          miscompares = 0;
   int          compares = 0;

   always #20 mclk = ~mclk;

   ddrcb_ctrl_model i_ddrcb_ctrl_model (.mclk(mclk), .pins(pins_in));
   ddrcb_core i_ddrcb_core (.mclk(mclk), .reset(reset), .pins_in(pins_in),
      .add_lat(add_lat), .burst_len8(burst_len8), .col_issue(col_issue),
      .bank_active(bank_active), .open_row(open_row), .self_refresh(self_refresh),
      .dll_on(dll_on), .refresh_busy(refresh_busy), .refresh_row(refresh_row),
      .cmd_error(cmd_error));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", n, exp, got);
      end
   endtask

   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
                      input logic k);
      i_ddrcb_ctrl_model.send(c, b, a, k);
   endtask

   task automatic nx(input int n);
      i_ddrcb_ctrl_model.idle(n);
   endtask

   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_act_rd();
      cmd(4'h3, 3'h5, 13'h1ABC, 1'b1);
      cmd(4'h5, 3'h5, 13'h0155, 1'b1);
      nx(3);
      chk("bank_active", bank_active, 8'h20);
      chk("open_row", open_row[5], 13'h1ABC);
      nx(1);
      chk("rd_issue", col_issue, {3'b100, 3'h5, 10'h155});
      $display("test act_rd done");
   endtask

   task automatic t_al();
      for (int al = 0; al <= AL_MAX; al++)
      begin
         add_lat = al[2:0];
         cmd(4'h4, 3'h5, 13'h0010 + al[12:0], 1'b1);
         nx(3 + al);
         chk("wr_early", col_issue.valid, 1'b0);
         nx(1);
         chk("wr_issue", col_issue, {3'b110, 3'h5, 10'h010 + al[9:0]});
      end
      add_lat = 3'h0;
      $display("test latency done");
   endtask

   task automatic t_ap();
      cmd(4'h5, 3'h5, 13'h0420, 1'b1);
      nx(4);
      chk("rd_ap", col_issue, {3'b101, 3'h5, 10'h020});
      chk("rd_ap_open", bank_active[5], 1'b1);
      nx(1);
      chk("rd_ap_shut", bank_active[5], 1'b0);
      burst_len8 = 1'b1;
      cmd(4'h3, 3'h2, 13'h0077, 1'b1);
      cmd(4'h4, 3'h2, 13'h0407, 1'b1);
      nx(4);
      chk("wr_ap", col_issue, {3'b111, 3'h2, 10'h007});
      nx(2);
      chk("wr_ap_open", bank_active[2], 1'b1);
      nx(T_WR_CYC + 3);
      chk("wr_ap_shut", bank_active, 8'h00);
      burst_len8 = 1'b0;
      $display("test auto precharge done");
   endtask

   task automatic t_prea();
      cmd(4'h3, 3'h0, 13'h0001, 1'b1);
      nx(2);
      cmd(4'h3, 3'h3, 13'h0002, 1'b1);
      nx(4);
      chk("two_open", bank_active, 8'h09);
      i_ddrcb_ctrl_model.prea();
      chk("prea", bank_active, 8'h00);
      $display("test precharge all done");
   endtask

   task automatic t_nop();
      cmd(4'h3, 3'h6, 13'h0003, 1'b1);
      cmd(4'h7, 3'h2, 13'h1FFF, 1'b1);
      cmd(4'h8, 3'h6, 13'h0400, 1'b1);
      cmd(4'hA, 3'h6, 13'h0400, 1'b1);
      repeat (5)
      begin
         nx(1);
         chk("quiet", {col_issue.valid, bank_active}, {1'b0, 8'h40});
      end
      $display("test nop done");
   endtask

   task automatic t_term();
      i_ddrcb_ctrl_model.term_update(13'h0044);
      nx(1);
      chk("term_quiet", {cmd_error, col_issue.valid, bank_active}, {2'b00, 8'h40});
      $display("test termination done");
   endtask

   task automatic t_err();
      for (int i = 0; i < 2; i++)
      begin
         cmd(i ? 4'h3 : 4'h5, i ? 3'h6 : 3'h1, 13'h0000, 1'b1);
         seen = 1'b0;
         repeat (6)
         begin
            nx(1);
            seen = seen | cmd_error;
         end
         chk("cmd_error", seen, 1'b1);
      end
      $display("test errors done");
   endtask

   task automatic t_ref();
      i_ddrcb_ctrl_model.prea();
      cmd(4'h1, 3'h0, 13'h1234, 1'b1);
      nx(4);
      chk("ref", {refresh_busy, bank_active, refresh_row}, {9'h100, 13'h0001});
      nx(T_RFC_CYC);
      $display("test refresh done");
   endtask

   task automatic t_sr();
      i_ddrcb_ctrl_model.sr_entry();
      nx(4);
      chk("sr_entry", {self_refresh, dll_on}, 2'b10);
      cmd(4'h5, 3'h6, 13'h0000, 1'b0);
      seen = 1'b0;
      repeat (6)
      begin
         nx(1);
         seen = seen | col_issue.valid | cmd_error | ~self_refresh;
      end
      chk("sr_ignores", seen, 1'b0);
      i_ddrcb_ctrl_model.sr_exit();
      chk("sr_exit", {self_refresh, dll_on, refresh_row}, {2'b01, 13'h0002});
      $display("test self refresh done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(negedge mclk);
      reset = 1'b0;
      t_act_rd();
      t_al();
      t_ap();
      t_prea();
      t_nop();
      t_term();
      t_err();
      t_ref();
      t_sr();
      finish_test();
   end

   // Tests need about 200 cycles
   initial
   begin
      repeat (3000) @(posedge mclk);
      miscompares++;
      finish_test();
   end
endmodule // ddrcb_core_tb
